//--- hdl/seb_defines.svh
// constants for the serial eeprom bus target: sizes, fields and write timing
`ifndef SEB_DEFINES_SVH
`define SEB_DEFINES_SVH

// ****************************************************************
// array and page geometry
// ****************************************************************
`define SEB_MEM_WORDS 32768
`define SEB_PAGE_BYTES 64
`define SEB_ADDR_W 15

// ****************************************************************
// serial word framing
// ****************************************************************
`define SEB_LAST_BIT 4'h7
`define SEB_ACK_SLOT 4'h8
`define SEB_DIR_BIT 0

// ****************************************************************
// write cycle timing
// ****************************************************************
`define SEB_CLK_PERIOD_NS 100
`define SEB_TWC_MAX_NS 5000000
`define SEB_TWC_CYC (`SEB_TWC_MAX_NS / `SEB_CLK_PERIOD_NS)

`endif

//--- hdl/seb_pkg.sv
// types shared by the serial eeprom bus target
package seb_pkg;

  // ****************************************************************
  // link side states, one per received or sent word kind
  // ****************************************************************
  typedef enum logic [2:0] {
    LK_IDLE,
    LK_DEV,
    LK_ADRH,
    LK_ADRL,
    LK_WDATA,
    LK_RDATA
  } seb_link_t;

  // ****************************************************************
  // programming timer states
  // ****************************************************************
  typedef enum logic {
    PG_IDLE,
    PG_BUSY
  } seb_prog_t;

endpackage

//--- hdl/seb_cond_if.sv
// bus condition signals between the condition detector and the core
`timescale 1ns/1ps

interface seb_cond_if;
  logic start_tog;
  logic stop_tog;
  logic stop_wr;
  logic armed;

  modport det (
    output start_tog,
    output stop_tog,
    output stop_wr,
    input armed
  );

  modport core (
    input start_tog,
    input stop_tog,
    input stop_wr,
    output armed
  );
endinterface

//--- hdl/seb_cond_det.sv
// start and stop condition detector clocked by the data line edges
`timescale 1ns/1ps

module seb_cond_det (
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  seb_cond_if.det cond
);

  logic start_tog;
  logic next_start_tog;
  logic stop_tog;
  logic next_stop_tog;
  logic stop_wr;
  logic next_stop_wr;

  // ****************************************************************
  // start: data falls while clock is high
  // ****************************************************************
  always_comb begin
    next_start_tog = start_tog;
    if (scl_i) begin
      next_start_tog = ~start_tog;
    end
  end

  always_ff @(negedge sda_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_tog <= 1'b0;
    end else begin
      start_tog <= next_start_tog;
    end
  end

  // ****************************************************************
  // stop: data rises while clock is high, catching pending write data
  // ****************************************************************
  always_comb begin
    next_stop_tog = stop_tog;
    next_stop_wr = stop_wr;
    if (scl_i) begin
      next_stop_tog = ~stop_tog;
      next_stop_wr = cond.armed;
    end
  end

  always_ff @(posedge sda_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_tog <= 1'b0;
      stop_wr <= 1'b0;
    end else begin
      stop_tog <= next_stop_tog;
      stop_wr <= next_stop_wr;
    end
  end

  // toggles leave on the interface
  assign cond.start_tog = start_tog;
  assign cond.stop_tog = stop_tog;
  assign cond.stop_wr = stop_wr;

endmodule

//--- hdl/seb_eeprom.sv
// serial eeprom bus target: link engine, page buffer, array and write timer
//
// How it works
// - sample on clock rise, drive after fall
// - data falling with clock high starts frame
// - data rising with clock high stops frame
// - stop after write data starts programming
// - eight-bit words, ninth clock carries acknowledge
// - master zero acknowledge fetches next read byte
// - no acknowledge: release line, send nothing
// - address word: type, strap select, direction
// - mismatch on type or straps: go idle
// - direction bit low writes, high reads
// - two address bytes then data, address always acknowledged, data unless protected
// - ignore bus while programming runs
// - up to 64 bytes, bump page offset
// - page offset wraps, later bytes overwrite
// - protected: address acked, first data refused
// - protect covers whole array, reads unaffected
// - programming lasts at most five milliseconds
// - address not acknowledged during programming
`timescale 1ns/1ps
`include "seb_defines.svh"

module seb_eeprom #(
  parameter logic [15:0] WC_CYCLES = 16'(`SEB_TWC_CYC),
  parameter logic [3:0] DEV_TYPE = 4'h6 // arbitrary device-type code
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [2:0] select_strap_pins_i,
  input wire logic write_protect_i,
  output logic busy_o
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0] mem [0:`SEB_MEM_WORDS-1];
  logic [7:0] pbuf [0:`SEB_PAGE_BYTES-1];

  // ****************************************************************
  // link side state, clocked by the serial clock
  // ****************************************************************
  seb_pkg::seb_link_t state;
  seb_pkg::seb_link_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic ack_go;
  logic next_ack_go;
  logic [7:0] rd_byte;
  logic [7:0] next_rd_byte;
  logic [`SEB_ADDR_W-1:0] addr;
  logic [`SEB_ADDR_W-1:0] next_addr;
  logic [`SEB_PAGE_BYTES-1:0] pvalid;
  logic [`SEB_PAGE_BYTES-1:0] next_pvalid;
  logic armed;
  logic next_armed;
  logic start_seen;
  logic next_start_seen;
  logic buf_we;
  logic [7:0] byte_in;
  logic start_pend;
  logic oe;
  logic next_oe;

  // pin synchronisers on the serial clock
  logic [2:0] strap_m;
  logic [2:0] strap_s;
  logic wp_m;
  logic wp_s;
  logic busy_m;
  logic busy_s;

  // ****************************************************************
  // system side state
  // ****************************************************************
  seb_pkg::seb_prog_t pstate;
  seb_pkg::seb_prog_t next_pstate;
  logic [15:0] timer;
  logic [15:0] next_timer;
  logic [6:0] idx;
  logic [6:0] next_idx;
  logic [2:0] stop_q;
  logic [1:0] wr_q;
  logic stop_evt;
  logic mem_we;

  // ****************************************************************
  // start and stop detection
  // ****************************************************************
  seb_cond_if cond_if ();

  seb_cond_det u_det (
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .cond(cond_if.det)
  );

  // pending write data is offered to the stop detector
  assign cond_if.armed = armed;
  assign start_pend = (cond_if.start_tog != start_seen);

  // ****************************************************************
  // level inputs brought onto the serial clock
  // ****************************************************************
  // straps, protect and busy settle during the first seven clocks of a frame
  always_ff @(posedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_m <= 3'h0;
      strap_s <= 3'h0;
      wp_m <= 1'b0;
      wp_s <= 1'b0;
      busy_m <= 1'b0;
      busy_s <= 1'b0;
    end else begin
      strap_m <= select_strap_pins_i;
      strap_s <= strap_m;
      wp_m <= write_protect_i;
      wp_s <= wp_m;
      busy_m <= busy_o;
      busy_s <= busy_m;
    end
  end

  // ****************************************************************
  // receive and protocol engine, rising serial clock
  // ****************************************************************
  // next values of the link state machine
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_ack_go = ack_go;
    next_rd_byte = rd_byte;
    next_addr = addr;
    next_pvalid = pvalid;
    next_armed = armed;
    next_start_seen = start_seen;
    buf_we = 1'b0;
    byte_in = {shreg[6:0], sda_i};
    if (start_pend) begin
      // first bit of a new frame, whatever came before
      next_start_seen = cond_if.start_tog;
      next_armed = 1'b0;
      next_state = seb_pkg::LK_DEV;
      next_shreg = {7'h00, sda_i};
      next_cnt = 4'h1;
      next_ack_go = 1'b0;
    end else if (state != seb_pkg::LK_IDLE) begin
      if (cnt < `SEB_ACK_SLOT) begin
        next_shreg = byte_in;
        next_cnt = cnt + 4'h1;
        if (cnt == `SEB_LAST_BIT) begin
          // eighth bit in: decide the ninth clock answer
          case (state)
            seb_pkg::LK_DEV: begin
              next_ack_go = (byte_in[7:4] == DEV_TYPE) &&
                            (byte_in[3:1] == strap_s) &&
                            !busy_s;
            end
            seb_pkg::LK_ADRH, seb_pkg::LK_ADRL: begin
              next_ack_go = 1'b1;
            end
            seb_pkg::LK_WDATA: begin
              next_ack_go = !wp_s;
              if (!wp_s) begin
                buf_we = 1'b1;
                next_pvalid[addr[5:0]] = 1'b1;
                next_armed = 1'b1;
              end
            end
            default: begin
              next_ack_go = 1'b0;
            end
          endcase
        end
      end else begin
        // ninth clock: act on the answer
        next_cnt = 4'h0;
        next_ack_go = 1'b0;
        case (state)
          seb_pkg::LK_DEV: begin
            if (!ack_go) begin
              next_state = seb_pkg::LK_IDLE;
            end else if (shreg[`SEB_DIR_BIT]) begin
              next_state = seb_pkg::LK_RDATA;
              next_rd_byte = mem[addr];
              next_addr = addr + 15'h0001;
              next_armed = 1'b0;
            end else begin
              next_state = seb_pkg::LK_ADRH;
              next_armed = 1'b0;
              next_pvalid = '0;
            end
          end
          seb_pkg::LK_ADRH: begin
            next_addr[14:8] = shreg[6:0];
            next_state = seb_pkg::LK_ADRL;
          end
          seb_pkg::LK_ADRL: begin
            next_addr[7:0] = shreg;
            next_state = seb_pkg::LK_WDATA;
          end
          seb_pkg::LK_WDATA: begin
            if (ack_go) begin
              next_addr[5:0] = addr[5:0] + 6'h01;
            end else begin
              next_state = seb_pkg::LK_IDLE;
            end
          end
          seb_pkg::LK_RDATA: begin
            if (!sda_i) begin
              next_rd_byte = mem[addr];
              next_addr = addr + 15'h0001;
            end else begin
              next_state = seb_pkg::LK_IDLE;
            end
          end
          default: begin
            next_state = seb_pkg::LK_IDLE;
          end
        endcase
      end
    end
  end

  // link state registers
  always_ff @(posedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= seb_pkg::LK_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      ack_go <= 1'b0;
      rd_byte <= 8'h00;
      addr <= 15'h0000;
      pvalid <= '0;
      armed <= 1'b0;
      start_seen <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      ack_go <= next_ack_go;
      rd_byte <= next_rd_byte;
      addr <= next_addr;
      pvalid <= next_pvalid;
      armed <= next_armed;
      start_seen <= next_start_seen;
    end
  end

  // page buffer, later bytes at the same offset overwrite earlier ones
  always_ff @(posedge scl_i) begin
    if (buf_we) begin
      pbuf[addr[5:0]] <= byte_in;
    end
  end

  // ****************************************************************
  // data line driver, falling serial clock
  // ****************************************************************
  // low drive for acknowledge and for zero data bits
  always_comb begin
    next_oe = 1'b0;
    if (start_pend) begin
      next_oe = 1'b0;
    end else if (state != seb_pkg::LK_IDLE && cnt == `SEB_ACK_SLOT) begin
      next_oe = ack_go;
    end else if (state == seb_pkg::LK_RDATA && cnt < `SEB_ACK_SLOT) begin
      next_oe = !rd_byte[3'(`SEB_LAST_BIT - cnt)];
    end
  end

  always_ff @(negedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe <= 1'b0;
    end else begin
      oe <= next_oe;
    end
  end

  // open drain: the pin only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = oe;

  // ****************************************************************
  // stop events onto the system clock
  // ****************************************************************
  // toggle and its data flag each pass two flops, the toggle one more
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_q <= 3'h0;
      wr_q <= 2'h0;
    end else if (ce_i) begin
      stop_q <= {stop_q[1:0], cond_if.stop_tog};
      wr_q <= {wr_q[0], cond_if.stop_wr};
    end
  end

  assign stop_evt = stop_q[2] ^ stop_q[1];

  // ****************************************************************
  // internally timed programming cycle
  // ****************************************************************
  // copy flagged page bytes, then hold busy until the cycle ends
  always_comb begin
    next_pstate = pstate;
    next_timer = timer;
    next_idx = idx;
    mem_we = 1'b0;
    case (pstate)
      seb_pkg::PG_IDLE: begin
        if (stop_evt && wr_q[1]) begin
          next_pstate = seb_pkg::PG_BUSY;
          next_timer = 16'h0000;
          next_idx = 7'h00;
        end
      end
      seb_pkg::PG_BUSY: begin
        next_timer = timer + 16'h0001;
        if (!idx[6]) begin
          mem_we = pvalid[idx[5:0]];
          next_idx = idx + 7'h01;
        end
        if (timer >= WC_CYCLES - 16'h0001 && idx[6]) begin
          next_pstate = seb_pkg::PG_IDLE;
        end
      end
      default: begin
        next_pstate = seb_pkg::PG_IDLE;
      end
    endcase
  end

  // timer registers, frozen while the clock enable is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pstate <= seb_pkg::PG_IDLE;
      timer <= 16'h0000;
      idx <= 7'h00;
    end else if (ce_i) begin
      pstate <= next_pstate;
      timer <= next_timer;
      idx <= next_idx;
    end
  end

  // array write; page buffer and address are still while busy
  always_ff @(posedge clk_i) begin
    if (ce_i && mem_we) begin
      mem[{addr[14:6], idx[5:0]}] <= pbuf[idx[5:0]];
    end
  end

  // busy shuts the link out until the cycle ends
  assign busy_o = (pstate == seb_pkg::PG_BUSY);

endmodule

//--- tb/seb_eeprom_checker.sv
// concurrent checks on the ports of the serial eeprom bus target
`timescale 1ns/1ps
module seb_eeprom_checker #(
  parameter logic [15:0] WC_CYCLES = 16'h0064,
  parameter logic [3:0] DEV_TYPE = 4'h6
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [2:0] select_strap_pins_i,
  input wire logic write_protect_i,
  input wire logic busy_o
);
  logic [15:0] busy_cnt;
  logic st_tog;
  logic st_seen;
  logic wr_fr;
  logic rd_fr;
  logic [3:0] bcnt;
  logic [7:0] word;
  logic [7:0] sh;
  logic dev_ok;
  // ****************
  // frame tracking
  // ****************
  // address word matches type code and straps
  assign dev_ok = (sh[7:4] == DEV_TYPE) && (sh[3:1] == select_strap_pins_i);
  // length of the current busy stretch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) busy_cnt <= 16'h0000;
    else if (ce_i) busy_cnt <= busy_o ? busy_cnt + 16'h0001 : 16'h0000;
  end
  // start seen: data falls while clock high
  always_ff @(negedge sda_i or negedge rst_n_i) begin
    if (!rst_n_i) st_tog <= 1'b0;
    else if (scl_i) st_tog <= ~st_tog;
  end
  // bit and word counts, received shift and frame direction
  always_ff @(posedge scl_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_seen <= 1'b0;
      bcnt <= 4'h9;
      word <= 8'h00;
      sh <= 8'h00;
      wr_fr <= 1'b0;
      rd_fr <= 1'b0;
    end else begin
      sh <= {sh[6:0], sda_i};
      st_seen <= st_tog;
      if (st_tog != st_seen) begin
        bcnt <= 4'h1;
        word <= 8'h00;
        wr_fr <= 1'b0;
        rd_fr <= 1'b0;
      end else if (bcnt == 4'h9) begin
        bcnt <= 4'h1;
        word <= word + 8'h01;
      end else begin
        bcnt <= bcnt + 4'h1;
        if (bcnt == 4'h8 && word == 8'h00) begin
          wr_fr <= sda_oe_o && !sh[0];
          rd_fr <= sda_oe_o && sh[0];
        end
      end
    end
  end
  // ****************
  // assertions
  // ****************
  chk_dev_release: assert property (@(posedge scl_i) disable iff (!rst_n_i)
    (word == 8'h00 && bcnt < 4'h8) |-> !sda_oe_o) else $error("drove data in address word");
  chk_dev_mismatch: assert property (@(posedge scl_i) disable iff (!rst_n_i)
    (word == 8'h00 && bcnt == 4'h8 && !dev_ok) |-> !sda_oe_o) else $error("acked foreign word");
  chk_dev_ack: assert property (@(posedge scl_i) disable iff (!rst_n_i)
    (word == 8'h00 && bcnt == 4'h8 && dev_ok && !busy_o && !$past(busy_o, 4)) |-> sda_oe_o)
    else $error("own address word not acked");
  chk_addr_ack: assert property (@(posedge scl_i) disable iff (!rst_n_i)
    (wr_fr && word inside {8'h01, 8'h02} && bcnt == 4'h8) |-> sda_oe_o)
    else $error("memory address byte not acked");
  chk_data_ack: assert property (@(posedge scl_i) disable iff (!rst_n_i)
    (wr_fr && word >= 8'h03 && bcnt == 4'h8) |-> (sda_oe_o == !write_protect_i))
    else $error("data ack wrong for protect level");
  chk_read_release: assert property (@(posedge scl_i) disable iff (!rst_n_i)
    (rd_fr && word != 8'h00 && bcnt == 4'h8) |-> !sda_oe_o) else $error("line held in ack slot");
  chk_nack_quiet: assert property (@(posedge scl_i) disable iff (!rst_n_i)
    (rd_fr && word != 8'h00 && bcnt == 4'h8 && sda_i) |=> !sda_oe_o [*8])
    else $error("data sent after no-ack");
  chk_busy_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    busy_cnt <= WC_CYCLES) else $error("programming ran too long");
  chk_busy_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    busy_o |-> !sda_oe_o) else $error("line driven while programming");
  chk_busy_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(busy_o) |-> (scl_i && sda_i)) else $error("programming began inside a frame");
  // main scenarios reached
  cov_wp: cover property (@(posedge scl_i) wr_fr && word == 8'h03 && write_protect_i);
  cov_page: cover property (@(posedge scl_i) wr_fr && word == 8'h44);
  cov_prog: cover property (@(posedge clk_i) $fell(busy_o));
endmodule

//--- tb/seb_master.sv
// two-wire bus master model: clock runs only inside frames
`timescale 1ns/1ps
module seb_master (
  output logic scl_o,
  output logic drv_o,
  input wire logic sda_i
);
  // ****************
  // conditions and bits
  // ****************
  // bus idle: clock high, data released
  initial begin
    scl_o = 1'b1;
    drv_o = 1'b0;
  end
  // start, also repeated: data falls while clock high
  task automatic mstart();
    drv_o = 1'b0;
    #40 scl_o = 1'b1;
    #40 drv_o = 1'b1;
    #40 scl_o = 1'b0;
  endtask
  // one bit slot: data changes only with clock low, sampled at clock high
  task automatic mbit(input logic b, output logic r);
    #40 drv_o = ~b;
    #40 scl_o = 1'b1;
    #80 r = sda_i;
    scl_o = 1'b0;
  endtask
  // stop: data rises while clock high, clock then stands high
  task automatic mstop();
    #40 drv_o = 1'b1;
    #40 scl_o = 1'b1;
    #40 drv_o = 1'b0;
    #40;
  endtask
  // send a word msb first, release for the ninth clock
  task automatic mwrite(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) mbit(d[i], r);
    mbit(1'b1, ack);
  endtask
  // take a word msb first, then answer in the ninth clock
  task automatic mread(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) mbit(1'b1, d[i]);
    mbit(ack, r);
  endtask
endmodule

//--- tb/serial_eeprom_bus_slave_tb.sv
// self-checking testbench for the serial eeprom bus target
`timescale 1ns/1ps
`include "seb_defines.svh"
bind seb_eeprom seb_eeprom_checker #(.WC_CYCLES(WC_CYCLES), .DEV_TYPE(DEV_TYPE)) chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .select_strap_pins_i(select_strap_pins_i),
  .write_protect_i(write_protect_i), .busy_o(busy_o));
module serial_eeprom_bus_slave_tb;
  localparam logic [15:0] WC = 16'h0064;
  localparam logic [3:0] DT = 4'h6; // arbitrary type code
  logic clk_i, rst_n_i, wp, busy, oe, scl, m_drv, ce, sdo;
  logic [2:0] straps;
  wire logic sda;
  int mismatches, check_count, cycles;
  // open-drain wire with pull-up
  assign sda = !m_drv && (!oe || sdo);
  seb_eeprom #(.WC_CYCLES(WC), .DEV_TYPE(DT)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .scl_i(scl), .sda_i(sda),
    .sda_o(sdo), .sda_oe_o(oe), .select_strap_pins_i(straps), .write_protect_i(wp),
    .busy_o(busy));
  seb_master m (.scl_o(scl), .drv_o(m_drv), .sda_i(sda));
  // ****************
  // shared tasks
  // ****************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // wait for busy to reach a level, bounded
  task automatic wait_busy(input logic v, input int lim);
    int n;
    n = 0;
    while (busy !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic dev(input logic rd, output logic k);
    m.mstart();
    m.mwrite({DT, straps, rd}, k);
  endtask
  task automatic set_addr(input logic [15:0] a);
    logic k;
    dev(1'b0, k);
    check(8'h00, {7'h00, k});
    m.mwrite(a[15:8], k);
    check(8'h00, {7'h00, k});
    m.mwrite(a[7:0], k);
    check(8'h00, {7'h00, k});
  endtask
  task automatic rd_start();
    logic k;
    dev(1'b1, k);
    check(8'h00, {7'h00, k});
  endtask
  task automatic wait_prog();
    wait_busy(1'b1, 20);
    check(8'h01, {7'h00, busy});
    wait_busy(1'b0, int'(WC) + 10);
    check(8'h00, {7'h00, busy});
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_byte();
    logic k;
    logic [7:0] d;
    set_addr(16'h9234);
    m.mwrite(8'hA5, k);
    check(8'h00, {7'h00, k});
    m.mstop();
    wait_prog();
    set_addr(16'h1234);
    rd_start();
    m.mread(1'b1, d);
    check(8'hA5, d);
    m.mstop();
  endtask
  task automatic t_poll();
    logic k;
    int n;
    set_addr(16'h0010);
    m.mwrite(8'h3C, k);
    m.mstop();
    wait_busy(1'b1, 20);
    dev(1'b0, k);
    check(8'h01, {7'h00, k});
    m.mstop();
    // clock enable low freezes the write timer, so busy outlasts its length
    @(negedge clk_i) ce = 1'b0;
    repeat (150) @(negedge clk_i);
    check(8'h01, {7'h00, busy});
    ce = 1'b1;
    n = 0;
    k = 1'b1;
    while (k && n < 200) begin
      dev(1'b0, k);
      m.mstop();
      n++;
    end
    check(8'h00, {7'h00, k});
    wait_busy(1'b0, `SEB_TWC_CYC);
  endtask
  task automatic t_mismatch();
    logic k;
    logic [7:0] bad [4];
    bad = '{{DT ^ 4'h1, straps, 1'b0}, {DT, straps ^ 3'h4, 1'b0},
            {DT, straps ^ 3'h2, 1'b1}, {DT, straps ^ 3'h1, 1'b0}};
    foreach (bad[i]) begin
      m.mstart();
      m.mwrite(bad[i], k);
      check(8'h01, {7'h00, k});
      m.mstop();
    end
  endtask
  // start at page offset 62, send 66 bytes: offset o ends holding o + 2
  task automatic t_page();
    logic k;
    logic [7:0] d;
    set_addr(16'h017E);
    for (int i = 0; i < 66; i++) begin
      m.mwrite(8'(i), k);
      check(8'h00, {7'h00, k});
    end
    m.mstop();
    wait_prog();
    set_addr(16'h0140);
    rd_start();
    for (int o = 0; o < 64; o++) begin
      m.mread(o == 63, d);
      check(8'(o + 2), d);
    end
    m.mread(1'b1, d);
    check(8'hFF, d);
    m.mstop();
  endtask
  task automatic t_wp();
    logic k;
    logic [7:0] d;
    @(negedge clk_i) wp = 1'b1;
    set_addr(16'h0140);
    m.mwrite(8'hC3, k);
    check(8'h01, {7'h00, k});
    m.mstop();
    wait_busy(1'b1, 20);
    check(8'h00, {7'h00, busy});
    set_addr(16'h0140);
    rd_start();
    m.mread(1'b1, d);
    check(8'h02, d);
    m.mstop();
    @(negedge clk_i) wp = 1'b0;
  endtask
  // ****************
  // clock, watchdog, sequence
  // ****************
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // cut a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    rst_n_i = 1'b0;
    wp = 1'b0;
    ce = 1'b1;
    straps = 3'h5;
    mismatches = 0;
    check_count = 0;
    cycles = 0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    #13;
    t_byte();
    t_poll();
    t_mismatch();
    t_page();
    t_wp();
    report_and_stop();
  end
endmodule
